/* File: rtl/bel_map.svh */
// register map, field positions and reset values of the bus error log
`ifndef BEL_MAP_SVH
`define BEL_MAP_SVH
`define BEL_ADR_STATUS   4'h0
`define BEL_ADR_EADDR_LO 4'h1
`define BEL_ADR_EADDR_HI 4'h2
`define BEL_ADR_MISS     4'h3
`define BEL_B_RD_LOST    39
`define BEL_B_RD_PAR     38
`define BEL_B_WR_LOST    37
`define BEL_B_WR_PAR     36
`define BEL_B_CA_LOST    35
`define BEL_B_CA_PAR     34
`define BEL_B_DIAG       33
`define BEL_B_MS_VALID   31
`define BEL_B_CNT_HI     30
`define BEL_B_CNT_LO     25
`define BEL_B_WR_NOACK   15
`define BEL_B_CA_NOACK   14
`define BEL_B_LW6        13
`define BEL_MISS_CNT_RST 6'h3e
`define BEL_MISS_CNT_MAX 6'h3f
`endif

/* File: rtl/bel_pkg.sv */
// types shared by the bus error log modules
package bel_pkg;
   typedef struct packed {
      logic rd_lost;
      logic rd_par;
      logic wr_lost;
      logic wr_par;
      logic ca_lost;
      logic ca_par;
      logic diag;
      logic wr_noack;
      logic ca_noack;
      logic lw6;
   } bel_flags_t;

   typedef struct packed {
      bel_flags_t  flags;
      logic        ms_valid;
      logic [31:0] sample;
      logic [63:0] ea_lo;
      logic [63:0] ea_hi;
      logic [63:0] rdata;
   } bel_state_t;

   typedef struct packed {
      logic [5:0] count;
   } bel_cnt_t;
endpackage

/* File: rtl/bel_miss_if.sv */
// miss counter link between the error log and its counter
`timescale 1ns/1ps
interface bel_miss_if;
   logic       miss;
   logic [5:0] count;
   logic       wrap;
   modport counter (input miss, output count, output wrap);
   modport user (output miss, input count, input wrap);
endinterface

/* File: rtl/bel_miss_counter.sv */
// free-running six-bit backup cache miss counter
`timescale 1ns/1ps
`include "bel_map.svh"
module bel_miss_counter
   import bel_pkg::*;
(
   input  wire logic       clk_sys_in,
   input  wire logic       rst_n_in,
   bel_miss_if.counter     miss_port
);
   bel_cnt_t cnt_q;
   bel_cnt_t cnt_d;

   always_comb
   begin
      cnt_d = cnt_q;
      if (miss_port.miss)
      begin
         cnt_d.count = cnt_q.count + 6'h01;
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         cnt_q.count <= `BEL_MISS_CNT_RST;
      end
      else
      begin
         cnt_q <= cnt_d;
      end
   end

   assign miss_port.count = cnt_q.count;
   // wrap marks the miss taken at a count of 3f: the second miss after reset, then every 64th
   assign miss_port.wrap = miss_port.miss && (cnt_q.count == `BEL_MISS_CNT_MAX);

   count_step_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      miss_port.miss |=> miss_port.count == $past(miss_port.count) + 6'h01)
      else $error("miss count did not step");
   count_hold_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      !miss_port.miss |=> $stable(miss_port.count))
      else $error("miss count moved without a miss");
endmodule

/* File: rtl/bel_status.sv */
// error status register of the odd half of the system bus interface
`timescale 1ns/1ps
`include "bel_map.svh"
module bel_status
   import bel_pkg::*;
(
   input  wire logic         clk_sys_in,
   input  wire logic         rst_n_in,
   input  wire logic [3:0]   reg_addr_in,
   input  wire logic [63:0]  reg_wdata_in,
   input  wire logic         reg_wr_in,
   input  wire logic         reg_rd_in,
   output logic      [63:0]  reg_rdata_out,
   input  wire logic         ca_cycle_in,
   input  wire logic [127:0] cad_in,
   input  wire logic         ca_par_err_in,
   input  wire logic         own_ca_par_err_in,
   input  wire logic         rd_par_err_in,
   input  wire logic         wr_par_err_in,
   input  wire logic         ca_noack_in,
   input  wire logic         wr_noack_in,
   input  wire logic         interchip_err_in,
   input  wire logic         lw6_err_in,
   input  wire logic         miss_in,
   input  wire logic [31:0]  miss_addr_in,
   output logic              miss_sample_valid_out,
   output logic              error_frozen_out
);
   bel_state_t st_q;
   bel_state_t st_d;
   bel_miss_if miss_link ();

   logic frozen;
   logic ca_err;
   logic wr_status;
   logic [63:0] clr;

   // every check in this module runs on the system clock and sleeps through reset
   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (!rst_n_in);

   // assemble the status word; undefined positions stay zero
   function automatic logic [63:0] status_word(input bel_flags_t f,
                                               input logic       v,
                                               input logic [5:0] c);
      logic [63:0] w;
      w = 64'h0;
      w[`BEL_B_RD_LOST]  = f.rd_lost;
      w[`BEL_B_RD_PAR]   = f.rd_par;
      w[`BEL_B_WR_LOST]  = f.wr_lost;
      w[`BEL_B_WR_PAR]   = f.wr_par;
      w[`BEL_B_CA_LOST]  = f.ca_lost;
      w[`BEL_B_CA_PAR]   = f.ca_par;
      w[`BEL_B_DIAG]     = f.diag;
      w[`BEL_B_MS_VALID] = v;
      w[`BEL_B_CNT_HI:`BEL_B_CNT_LO] = c;
      w[`BEL_B_WR_NOACK] = f.wr_noack;
      w[`BEL_B_CA_NOACK] = f.ca_noack;
      w[`BEL_B_LW6]      = f.lw6;
      return w;
   endfunction

   bel_miss_counter u_miss_counter
   (
      .clk_sys_in (clk_sys_in),
      .rst_n_in   (rst_n_in),
      .miss_port  (miss_link.counter)
   );

   assign miss_link.miss = miss_in;

   // the lost flags and the diagnostic bit do not hold the address registers
   assign frozen = st_q.flags.rd_par | st_q.flags.wr_par | st_q.flags.ca_par
                 | st_q.flags.wr_noack | st_q.flags.ca_noack;
   // own commander cycles are checked like any other node's
   assign ca_err    = ca_par_err_in | own_ca_par_err_in;
   assign wr_status = reg_wr_in && (reg_addr_in == `BEL_ADR_STATUS);
   assign clr       = wr_status ? reg_wdata_in : 64'h0;

   always_comb
   begin
      st_d = st_q;
      st_d.rdata = 64'h0;

      // write one to clear, an error event in the same cycle wins; a clear of a pending sample beats a wrap
      if (clr[`BEL_B_RD_LOST])
      begin
         st_d.flags.rd_lost = 1'b0;
      end
      if (clr[`BEL_B_RD_PAR])
      begin
         st_d.flags.rd_par = 1'b0;
      end
      if (clr[`BEL_B_WR_LOST])
      begin
         st_d.flags.wr_lost = 1'b0;
      end
      if (clr[`BEL_B_WR_PAR])
      begin
         st_d.flags.wr_par = 1'b0;
      end
      if (clr[`BEL_B_CA_LOST])
      begin
         st_d.flags.ca_lost = 1'b0;
      end
      if (clr[`BEL_B_CA_PAR])
      begin
         st_d.flags.ca_par = 1'b0;
      end
      if (clr[`BEL_B_DIAG])
      begin
         st_d.flags.diag = 1'b0;
      end
      if (clr[`BEL_B_WR_NOACK])
      begin
         st_d.flags.wr_noack = 1'b0;
      end
      if (clr[`BEL_B_CA_NOACK])
      begin
         st_d.flags.ca_noack = 1'b0;
      end
      if (clr[`BEL_B_MS_VALID])
      begin
         st_d.ms_valid = 1'b0;
      end

      // primary flags always record; lost flags when the address is held
      if (rd_par_err_in)
      begin
         st_d.flags.rd_par = 1'b1;
         if (frozen)
         begin
            st_d.flags.rd_lost = 1'b1;
         end
      end
      if (wr_par_err_in)
      begin
         st_d.flags.wr_par = 1'b1;
      end
      if ((wr_par_err_in || wr_noack_in) && frozen)
      begin
         st_d.flags.wr_lost = 1'b1;
      end
      if (ca_err)
      begin
         st_d.flags.ca_par = 1'b1;
      end
      if ((ca_err || ca_noack_in) && frozen)
      begin
         st_d.flags.ca_lost = 1'b1;
      end
      // write no-ack also covers a victim pushed outside memory
      if (wr_noack_in)
      begin
         st_d.flags.wr_noack = 1'b1;
      end
      if (ca_noack_in)
      begin
         st_d.flags.ca_noack = 1'b1;
      end
      // diagnostic events never touch the address registers
      if (interchip_err_in)
      begin
         st_d.flags.diag = 1'b1;
      end

      // word-six data error is set by its event and then held only while a data flag is up
      st_d.flags.lw6 = lw6_err_in
                     | (st_q.flags.lw6 & (st_d.flags.rd_par | st_d.flags.wr_par));

      // the address registers follow the bus until an error holds them
      if (!frozen)
      begin
         if (wr_noack_in)
         begin
            st_d.ea_lo = cad_in[63:0];
            st_d.ea_hi = cad_in[127:64];
         end
         else if (ca_noack_in)
         begin
            // only the low halves carry the failing address
            st_d.ea_lo[31:0] = cad_in[31:0];
            st_d.ea_hi[31:0] = cad_in[95:64];
         end
         else if (ca_cycle_in)
         begin
            st_d.ea_lo = cad_in[63:0];
            st_d.ea_hi = cad_in[127:64];
         end
      end

      // sample one miss address per counter round, unless one is pending
      // software must clear the valid flag to rearm; the count never stops
      if (miss_link.wrap && !st_q.ms_valid)
      begin
         st_d.ms_valid = 1'b1;
         st_d.sample   = miss_addr_in;
      end

      if (reg_rd_in)
      begin
         unique case (reg_addr_in)
            `BEL_ADR_STATUS:
            begin
               st_d.rdata = status_word(st_q.flags, st_q.ms_valid, miss_link.count);
            end
            `BEL_ADR_EADDR_LO:
            begin
               st_d.rdata = st_q.ea_lo;
            end
            `BEL_ADR_EADDR_HI:
            begin
               st_d.rdata = st_q.ea_hi;
            end
            `BEL_ADR_MISS:
            begin
               st_d.rdata = {32'h0, st_q.sample[31:1], st_q.ms_valid};
            end
            default:
            begin
               st_d.rdata = 64'h0;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         st_q <= '0;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   assign reg_rdata_out         = st_q.rdata;
   assign miss_sample_valid_out = st_q.ms_valid;
   assign error_frozen_out      = frozen;

   sequence s_wrap_free;
      miss_in && miss_link.count == `BEL_MISS_CNT_MAX && !st_q.ms_valid;
   endsequence

   sequence s_status_read;
      reg_rd_in && reg_addr_in == `BEL_ADR_STATUS;
   endsequence

   sequence s_sample_read;
      reg_rd_in && reg_addr_in == `BEL_ADR_MISS;
   endsequence

   rd_par_set_a: assert property (rd_par_err_in |=> st_q.flags.rd_par)
      else $error("read parity flag not set");
   wr_lost_set_a: assert property (wr_par_err_in && frozen |=> st_q.flags.wr_lost)
      else $error("write lost flag not set");
   wr_lost_free_a: assert property (
      !frozen && !st_q.flags.wr_lost |=> !st_q.flags.wr_lost)
      else $error("write lost flag set without a held address");
   wr_par_set_a: assert property (wr_par_err_in |=> st_q.flags.wr_par)
      else $error("write parity flag not set");
   ca_lost_set_a: assert property (ca_err && frozen |=> st_q.flags.ca_lost)
      else $error("command lost flag not set");
   ca_par_set_a: assert property (ca_par_err_in |=> st_q.flags.ca_par)
      else $error("command parity flag not set");
   own_ca_check_a: assert property (own_ca_par_err_in |=> st_q.flags.ca_par)
      else $error("own command parity error not logged");
   diag_flag_a: assert property (
      interchip_err_in && !frozen && !ca_cycle_in && !ca_noack_in && !wr_noack_in
      |=> st_q.flags.diag && $stable(st_q.ea_lo) && $stable(st_q.ea_hi))
      else $error("diagnostic event mishandled");
   miss_sample_a: assert property (
      s_wrap_free |=> st_q.ms_valid && st_q.sample == $past(miss_addr_in))
      else $error("miss address not sampled on overflow");
   sample_hold_a: assert property (
      st_q.ms_valid && !clr[`BEL_B_MS_VALID] |=> $stable(st_q.sample) && st_q.ms_valid)
      else $error("pending miss sample overwritten");
   no_early_sample_a: assert property (
      !st_q.ms_valid && !(miss_in && miss_link.count == `BEL_MISS_CNT_MAX)
      |=> !st_q.ms_valid)
      else $error("sample valid set before counter overflow");
   mirror_read_a: assert property (
      s_sample_read |=> reg_rdata_out[0] == $past(st_q.ms_valid))
      else $error("sample valid copy wrong");
   count_read_a: assert property (
      s_status_read |=> reg_rdata_out[`BEL_B_CNT_HI:`BEL_B_CNT_LO] == $past(miss_link.count))
      else $error("miss count field wrong");
   wr_noack_log_a: assert property (
      wr_noack_in && !frozen |=> st_q.flags.wr_noack && st_q.ea_hi == $past(cad_in[127:64]))
      else $error("write no-ack not logged");
   ca_noack_log_a: assert property (
      ca_noack_in |=> st_q.flags.ca_noack)
      else $error("command no-ack flag not set");
   ca_noack_low_a: assert property (
      ca_noack_in && !wr_noack_in && !frozen
      |=> st_q.ea_lo[63:32] == $past(st_q.ea_lo[63:32])
          && st_q.ea_lo[31:0] == $past(cad_in[31:0]))
      else $error("command no-ack address logged in wrong half");
   w1c_clear_a: assert property (
      wr_status && reg_wdata_in[`BEL_B_RD_PAR] && !rd_par_err_in |=> !st_q.flags.rd_par)
      else $error("write one did not clear");
   w0_keep_a: assert property (
      wr_status && !reg_wdata_in[`BEL_B_CA_PAR] && st_q.flags.ca_par |=> st_q.flags.ca_par)
      else $error("write zero cleared a flag");
   lw6_drop_a: assert property (
      !st_d.flags.rd_par && !st_d.flags.wr_par && !lw6_err_in |=> !st_q.flags.lw6)
      else $error("word-six flag outlived data flags");
   freeze_hold_a: assert property (
      frozen |=> $stable(st_q.ea_lo) && $stable(st_q.ea_hi))
      else $error("error address moved while held");
   reserved_zero_a: assert property (
      s_status_read |=> reg_rdata_out[63:40] == 24'h0 && reg_rdata_out[24:16] == 9'h0
                        && reg_rdata_out[12:0] == 13'h0 && reg_rdata_out[32] == 1'b0)
      else $error("undefined status bits not zero");

   // lost flags: a second error while the address is held
   rd_lost_set_a: assert property (rd_par_err_in && frozen |=> st_q.flags.rd_lost)
      else $error("read lost flag not set");
   ca_lost_free_a: assert property (
      !frozen && !st_q.flags.ca_lost |=> !st_q.flags.ca_lost)
      else $error("command lost flag set without a held address");
   wr_noack_lost_a: assert property (wr_noack_in && frozen |=> st_q.flags.wr_lost)
      else $error("write no-ack while held not counted as lost");
   ca_noack_lost_a: assert property (ca_noack_in && frozen |=> st_q.flags.ca_lost)
      else $error("command no-ack while held not counted as lost");

   // address capture on a missing acknowledge
   wr_noack_low_a: assert property (
      wr_noack_in && !frozen |=> st_q.ea_lo == $past(cad_in[63:0]))
      else $error("write no-ack low address not logged");
   ca_noack_high_a: assert property (
      ca_noack_in && !wr_noack_in && !frozen
      |=> st_q.ea_hi[63:32] == $past(st_q.ea_hi[63:32])
          && st_q.ea_hi[31:0] == $past(cad_in[95:64]))
      else $error("command no-ack high address logged in wrong half");

   // sample valid and word-six bookkeeping
   sample_clear_a: assert property (
      wr_status && reg_wdata_in[`BEL_B_MS_VALID]
      && !(miss_in && miss_link.count == `BEL_MISS_CNT_MAX) |=> !st_q.ms_valid)
      else $error("sample valid did not clear");
   lw6_set_a: assert property (lw6_err_in |=> st_q.flags.lw6)
      else $error("word-six flag not set");
endmodule

/* File: sim/bel_bus_node.sv */
// far-side bus nodes: replay one kind of bus event for a given number of cycles
`timescale 1ns/1ps
module bel_bus_node
(
   input  wire logic         clk_sys_in,
   input  wire logic         rst_n_in,
   input  wire logic         go_in,
   input  wire logic [3:0]   kind_in,
   input  wire logic [6:0]   num_in,
   input  wire logic [127:0] data_in,
   output logic      [9:0]   ev_out,
   output logic      [127:0] cad_out,
   output logic      [31:0]  miss_addr_out
);
   logic [6:0] rem_q;
   logic [6:0] idx_q;
   logic [3:0] kind_q;

   always_ff @(posedge clk_sys_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         rem_q         <= 7'h00;
         idx_q         <= 7'h00;
         kind_q        <= 4'h0;
         ev_out        <= 10'h000;
         cad_out       <= 128'h0;
         miss_addr_out <= 32'h0;
      end
      else
      begin
         ev_out <= 10'h000;
         if (go_in)
         begin
            rem_q  <= num_in;
            idx_q  <= 7'h00;
            kind_q <= kind_in;
         end
         else if (rem_q != 7'h00)
         begin
            ev_out[kind_q] <= 1'b1;
            // a command parity error (kind 1 or 2) is only seen together with its c/a cycle
            if (kind_q == 4'h1 || kind_q == 4'h2)
               ev_out[0] <= 1'b1;
            cad_out       <= data_in;
            miss_addr_out <= data_in[31:0] + {25'h0, idx_q};
            rem_q         <= rem_q - 7'h01;
            idx_q         <= idx_q + 7'h01;
         end
         else
         begin
            // an idle bus must not look like it still holds the last address
            cad_out       <= ~cad_out;
            miss_addr_out <= ~miss_addr_out;
         end
      end
   end
endmodule

/* File: sim/bus_error_log_odd_half_bench.sv */
// self-checking bench for the odd-half bus error status register
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin fail_count++; $display("ERROR t=%0t got=%h exp=%h", $time, a, e); end end
module bus_error_log_odd_half_bench;
   localparam logic [63:0]  BASE = 64'h0000_0000_7c00_0000;
   localparam logic [127:0] CA   = 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210;
   localparam logic [127:0] CB   = 128'h1111_2222_3333_4444_5555_6666_7777_8888;
   logic         clk_sys_in   = 1'b0;
   logic         rst_n_in     = 1'b0;
   logic [3:0]   reg_addr_in  = 4'h0;
   logic [63:0]  reg_wdata_in = 64'h0;
   logic         reg_wr_in    = 1'b0;
   logic         reg_rd_in    = 1'b0;
   logic [63:0]  reg_rdata_out;
   logic         miss_sample_valid_out;
   logic         error_frozen_out;
   logic         go           = 1'b0;
   logic [3:0]   kind         = 4'h0;
   logic [6:0]   num          = 7'h00;
   logic [127:0] data         = 128'h0;
   logic [9:0]   ev;
   logic [127:0] cad;
   logic [31:0]  maddr;
   int           fail_count   = 0;
   int           checks       = 0;

   always #20 clk_sys_in = ~clk_sys_in;

   bel_bus_node u_node (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .go_in(go),
      .kind_in(kind), .num_in(num), .data_in(data), .ev_out(ev), .cad_out(cad),
      .miss_addr_out(maddr));

   bel_status u_dut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
      .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
      .reg_rdata_out(reg_rdata_out), .ca_cycle_in(ev[0]), .cad_in(cad),
      .ca_par_err_in(ev[1]), .own_ca_par_err_in(ev[2]), .rd_par_err_in(ev[3]),
      .wr_par_err_in(ev[4]), .ca_noack_in(ev[5]), .wr_noack_in(ev[6]),
      .interchip_err_in(ev[7]), .lw6_err_in(ev[8]), .miss_in(ev[9]), .miss_addr_in(maddr),
      .miss_sample_valid_out(miss_sample_valid_out), .error_frozen_out(error_frozen_out));

   function automatic logic [63:0] bt(input int n);
      return 64'h1 << n;
   endfunction

   task automatic wr(input logic [3:0] a, input logic [63:0] d);
      @(posedge clk_sys_in);
      reg_addr_in  <= a;
      reg_wdata_in <= d;
      reg_wr_in    <= 1'b1;
      @(posedge clk_sys_in);
      reg_wr_in <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, input logic [63:0] e);
      @(posedge clk_sys_in);
      reg_addr_in <= a;
      reg_rd_in   <= 1'b1;
      @(posedge clk_sys_in);
      reg_rd_in <= 1'b0;
      @(negedge clk_sys_in);
      `CHK(reg_rdata_out, e)
   endtask

   // the node needs one edge to pick up the order and n edges to replay it
   task automatic ev_run(input logic [3:0] k, input logic [6:0] n, input logic [127:0] d);
      @(posedge clk_sys_in);
      go   <= 1'b1;
      kind <= k;
      num  <= n;
      data <= d;
      @(posedge clk_sys_in);
      go <= 1'b0;
      repeat (n + 2) @(posedge clk_sys_in);
   endtask

   task automatic t_reset;
      rd(4'h0, BASE);
      rd(4'h3, 64'h0);
      rd(4'h9, 64'h0);
      `CHK(miss_sample_valid_out, 1'b0)
      $display("test reset done");
   endtask

   task automatic t_rdpar;
      ev_run(4'h3, 7'd1, CA);
      rd(4'h0, BASE | bt(38));
      `CHK(error_frozen_out, 1'b1)
      ev_run(4'h3, 7'd1, CA);
      rd(4'h0, BASE | bt(38) | bt(39));
      wr(4'h0, 64'h0);
      rd(4'h0, BASE | bt(38) | bt(39));
      wr(4'h0, bt(38));
      rd(4'h0, BASE | bt(39));
      wr(4'h0, bt(39));
      rd(4'h0, BASE);
      $display("test read parity done");
   endtask

   task automatic t_ca;
      ev_run(4'h1, 7'd1, CA);
      rd(4'h0, BASE | bt(34));
      rd(4'h1, CA[63:0]);
      rd(4'h2, CA[127:64]);
      ev_run(4'h1, 7'd1, CB);
      rd(4'h0, BASE | bt(34) | bt(35));
      rd(4'h1, CA[63:0]);
      wr(4'h0, bt(35));
      rd(4'h0, BASE | bt(34));
      wr(4'h0, bt(34));
      ev_run(4'h2, 7'd1, CB);
      rd(4'h0, BASE | bt(34));
      rd(4'h1, CB[63:0]);
      wr(4'h0, bt(34));
      ev_run(4'h7, 7'd1, CA);
      rd(4'h0, BASE | bt(33));
      ev_run(4'h0, 7'd1, CA);
      rd(4'h1, CA[63:0]);
      wr(4'h0, bt(33));
      rd(4'h0, BASE);
      $display("test command address done");
   endtask

   task automatic t_wr;
      ev_run(4'h4, 7'd1, CA);
      rd(4'h0, BASE | bt(36));
      ev_run(4'h4, 7'd1, CA);
      rd(4'h0, BASE | bt(36) | bt(37));
      ev_run(4'h8, 7'd1, CA);
      rd(4'h0, BASE | bt(36) | bt(37) | bt(13));
      wr(4'h0, bt(36) | bt(37) | bt(13));
      rd(4'h0, BASE);
      $display("test write parity done");
   endtask

   task automatic t_noack;
      ev_run(4'h6, 7'd1, CB);
      rd(4'h0, BASE | bt(15));
      rd(4'h1, CB[63:0]);
      rd(4'h2, CB[127:64]);
      ev_run(4'h6, 7'd1, CA);
      rd(4'h0, BASE | bt(15) | bt(37));
      rd(4'h1, CB[63:0]);
      wr(4'h0, bt(15) | bt(37));
      ev_run(4'h5, 7'd1, CA);
      rd(4'h0, BASE | bt(14));
      rd(4'h1, {CB[63:32], CA[31:0]});
      rd(4'h2, {CB[127:96], CA[95:64]});
      ev_run(4'h5, 7'd1, CB);
      rd(4'h0, BASE | bt(14) | bt(35));
      wr(4'h1, 64'hffff_ffff_ffff_ffff);
      rd(4'h1, {CB[63:32], CA[31:0]});
      wr(4'h0, 64'hffff_ffff_ffff_ffff);
      rd(4'h0, BASE);
      $display("test no acknowledge done");
   endtask

   task automatic t_miss;
      logic [31:0] s;
      s = CA[31:0] + 32'd63;
      ev_run(4'h9, 7'd1, CA);
      rd(4'h0, 64'h7e00_0000);
      ev_run(4'h9, 7'd1, CB);
      rd(4'h0, bt(31));
      rd(4'h3, {32'h0, CB[31:1], 1'b1});
      `CHK(miss_sample_valid_out, 1'b1)
      ev_run(4'h9, 7'd64, CA);
      rd(4'h0, bt(31));
      rd(4'h3, {32'h0, CB[31:1], 1'b1});
      wr(4'h0, bt(31));
      rd(4'h0, 64'h0);
      ev_run(4'h9, 7'd64, CA);
      rd(4'h3, {32'h0, s[31:1], 1'b1});
      $display("test miss sampling done");
   endtask

   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   initial
   begin
      // whole run is well under a thousand cycles
      #(40 * 20000);
      fail_count++;
      print_verdict();
   end

   initial
   begin
      repeat (20) @(posedge clk_sys_in);
      rst_n_in <= 1'b1;
      t_reset();
      t_rdpar();
      t_ca();
      t_wr();
      t_noack();
      t_miss();
      print_verdict();
   end
endmodule
